/* core/cmpbr_pkg.sv */
// Shared constants and types for the compare-and-branch-unequal executor.
// Assumes one core clock, a synchronous active-high reset, and a data
// memory that answers a read one cycle after the read strobe.
package cmpbr_pkg;

  // ==========================================================
  // Widths
  localparam int PC_W      = 17;
  localparam int ADDR_W    = 16;
  localparam int PSW_W     = 8;
  localparam int CARRY_BIT = 7;

  // ==========================================================
  // Opcodes and address pages
  localparam logic [7:0] OP_DISP_IND  = 8'h12;
  localparam logic [7:0] OP_DIR_PG00  = 8'h14;
  localparam logic [7:0] OP_DIR_PG01  = 8'h15;
  localparam logic [7:0] OP_DIR_PGFE  = 8'h13;
  localparam logic [7:0] OP_DIR_LONG  = 8'h16;
  localparam logic [7:0] PAGE_00      = 8'h00;
  localparam logic [7:0] PAGE_01      = 8'h01;
  localparam logic [7:0] PAGE_FE      = 8'hFE;
  localparam int         DISP_SEL_BIT = 7;

  // ==========================================================
  // Lengths and cycle counts
  localparam logic [PC_W-1:0] LEN_SHORT = 17'h00003;
  localparam logic [PC_W-1:0] LEN_LONG  = 17'h00004;
  localparam int              CYC_SHORT = 2;
  localparam int              CYC_LONG  = 3;

  // ==========================================================
  // Reset values
  localparam logic [PC_W-1:0]   PC_RST   = 17'h00000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [7:0]        BYTE_RST = 8'h00;
  localparam logic [PSW_W-1:0]  PSW_RST  = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_READ = 2'b10,
    ST_CMP  = 2'b11
  } exec_state_t;

  typedef enum logic {
    SRC_IMM = 1'b0,
    SRC_ACC = 1'b1
  } cmp_src_t;

endpackage : cmpbr_pkg

/* core/cmpbr_decode.sv */
// Opcode decoder for the three compare-and-branch-unequal forms.
// Purely combinational; the executor samples its outputs on acceptance.
`timescale 1ns/1ns
`default_nettype none

module cmpbr_decode (
  // Instruction bytes
  input  wire logic [7:0]                  i_op0,
  input  wire logic [7:0]                  i_op1,
  input  wire logic [7:0]                  i_op2,
  input  wire logic [7:0]                  i_op3,
  // Pointer zero contents
  input  wire logic [cmpbr_pkg::ADDR_W-1:0] i_ptr0,
  // Decoded fields
  output logic                             o_valid,
  output logic                             o_long,
  output cmpbr_pkg::cmp_src_t              o_src,
  output logic [cmpbr_pkg::ADDR_W-1:0]      o_addr,
  output logic [7:0]                       o_imm,
  output logic [7:0]                       o_disp
);

  logic [cmpbr_pkg::ADDR_W-1:0] off_ext;

  // Signed 7-bit offset, address wraps within 64 KiB
  assign off_ext = {{(cmpbr_pkg::ADDR_W-7){i_op1[6]}}, i_op1[6:0]};

  always_comb begin
    o_valid = 1'b0;
    o_long  = 1'b0;
    o_src   = cmpbr_pkg::SRC_ACC;
    o_addr  = {i_op2, i_op1};
    o_imm   = i_op2;
    o_disp  = i_op3;
    case (i_op0)
      cmpbr_pkg::OP_DISP_IND: begin
        // Top bit clear selects another indirect form, not handled here
        o_valid = i_op1[cmpbr_pkg::DISP_SEL_BIT];
        o_long  = 1'b1;
        o_src   = cmpbr_pkg::SRC_IMM;
        o_addr  = i_ptr0 + off_ext;
      end
      cmpbr_pkg::OP_DIR_PG00: begin
        o_valid = 1'b1;
        o_addr  = {cmpbr_pkg::PAGE_00, i_op1};
        o_disp  = i_op2;
      end
      cmpbr_pkg::OP_DIR_PG01: begin
        o_valid = 1'b1;
        o_addr  = {cmpbr_pkg::PAGE_01, i_op1};
        o_disp  = i_op2;
      end
      cmpbr_pkg::OP_DIR_PGFE: begin
        o_valid = 1'b1;
        o_addr  = {cmpbr_pkg::PAGE_FE, i_op1};
        o_disp  = i_op2;
      end
      cmpbr_pkg::OP_DIR_LONG: begin
        o_valid = 1'b1;
        o_long  = 1'b1;
      end
      default: begin
        o_valid = 1'b0;
      end
    endcase
  end

endmodule : cmpbr_decode

`default_nettype wire

/* core/cmpbr_exec.sv */
// Executor for the compare-and-branch-unequal instruction group.
// Assumes fetch presents all instruction bytes with a start strobe and
// that data memory returns a byte the cycle after the read strobe.
//
// Contract
// - Indirect form, byte differs: PC becomes PC plus 4 plus displacement.
// - Indirect form, byte equal: PC advances by 4 only.
// - Indirect form: carry set when memory byte below immediate, else clear.
// - Offset is signed 7-bit, -64..63, added to pointer zero contents.
// - Indirect form is four bytes, second byte top bit set; 3 cycles.
// - Short direct forms 14H, 15H, 13H select pages 00, 01, FE.
// - Other addresses use 16H with high byte; short 2, long 3 cycles.
// - Direct form, accumulator differs: PC plus length plus displacement.
// - Direct form, accumulator equal: PC advances by length only.
// - Accumulator forms: carry set when accumulator below byte, else clear.
// - Long-range form is 16H, low, high, displacement; 4 bytes, 3 cycles.
// - Long-range form, differs: PC becomes PC plus 4 plus displacement.
// - Long-range form, equal: PC advances by 4.
`timescale 1ns/1ns
`default_nettype none

module cmpbr_exec (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Instruction from fetch
  input  wire logic                        i_start,
  input  wire logic [7:0]                  i_op0,
  input  wire logic [7:0]                  i_op1,
  input  wire logic [7:0]                  i_op2,
  input  wire logic [7:0]                  i_op3,
  // Core state
  input  wire logic [cmpbr_pkg::PC_W-1:0]   i_pc,
  input  wire logic [7:0]                  i_acc,
  input  wire logic [cmpbr_pkg::ADDR_W-1:0] i_ptr0,
  input  wire logic [cmpbr_pkg::PSW_W-1:0]  i_psw,
  // Start handshake
  output logic                             o_accept,
  output logic                             o_reject,
  output logic                             o_busy,
  // Data memory and special register space
  output logic                             o_mem_rd,
  output logic [cmpbr_pkg::ADDR_W-1:0]      o_mem_addr,
  input  wire logic [7:0]                  i_mem_rdata,
  // Results
  output logic                             o_done,
  output logic                             o_branch,
  output logic [cmpbr_pkg::PC_W-1:0]        o_pc,
  output logic [cmpbr_pkg::PSW_W-1:0]       o_psw
);

  // ==========================================================
  // Decode
  logic                          dec_valid;
  logic                          dec_long;
  cmpbr_pkg::cmp_src_t           dec_src;
  logic [cmpbr_pkg::ADDR_W-1:0]  dec_addr;
  logic [7:0]                    dec_imm;
  logic [7:0]                    dec_disp;

  cmpbr_decode cmpbr_decode_inst (
    .i_op0   (i_op0),
    .i_op1   (i_op1),
    .i_op2   (i_op2),
    .i_op3   (i_op3),
    .i_ptr0  (i_ptr0),
    .o_valid (dec_valid),
    .o_long  (dec_long),
    .o_src   (dec_src),
    .o_addr  (dec_addr),
    .o_imm   (dec_imm),
    .o_disp  (dec_disp)
  );

  // ==========================================================
  // Instruction state
  cmpbr_pkg::exec_state_t        state;
  cmpbr_pkg::exec_state_t        next_state;
  cmpbr_pkg::cmp_src_t           src;
  cmpbr_pkg::cmp_src_t           next_src;
  logic [cmpbr_pkg::PC_W-1:0]    pc;
  logic [cmpbr_pkg::PC_W-1:0]    next_pc;
  logic [cmpbr_pkg::PC_W-1:0]    len;
  logic [cmpbr_pkg::PC_W-1:0]    next_len;
  logic [7:0]                    opnd;
  logic [7:0]                    next_opnd;
  logic [7:0]                    disp;
  logic [7:0]                    next_disp;
  logic [cmpbr_pkg::PSW_W-1:0]   psw;
  logic [cmpbr_pkg::PSW_W-1:0]   next_psw;
  logic [cmpbr_pkg::ADDR_W-1:0]  next_mem_addr;

  // Result registers
  logic                          next_done;
  logic                          next_branch;
  logic [cmpbr_pkg::PC_W-1:0]    next_res_pc;
  logic [cmpbr_pkg::PSW_W-1:0]   next_res_psw;

  // Compare helpers
  logic [cmpbr_pkg::PC_W-1:0]    disp_ext;
  logic                          differ;
  logic                          carry;

  // Displacement is signed 8-bit
  assign disp_ext = {{(cmpbr_pkg::PC_W-8){disp[7]}}, disp};
  assign differ   = (i_mem_rdata != opnd);
  // Unsigned byte compare; direction depends on which side is memory
  always_comb begin
    if (src == cmpbr_pkg::SRC_IMM) begin
      carry = (i_mem_rdata < opnd);
    end else begin
      carry = (opnd < i_mem_rdata);
    end
  end

  // Handshake outputs combinational so fetch can advance the same cycle
  assign o_busy   = (state != cmpbr_pkg::ST_IDLE);
  assign o_accept = !o_busy && i_start && dec_valid;
  assign o_reject = !o_busy && i_start && !dec_valid;
  // Read strobe only: nothing in memory or the accumulator is written
  assign o_mem_rd = (state == cmpbr_pkg::ST_READ);

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state    = state;
    next_src      = src;
    next_pc       = pc;
    next_len      = len;
    next_opnd     = opnd;
    next_disp     = disp;
    next_psw      = psw;
    next_mem_addr = o_mem_addr;
    next_done     = 1'b0;
    next_branch   = o_branch;
    next_res_pc   = o_pc;
    next_res_psw  = o_psw;
    case (state)
      cmpbr_pkg::ST_IDLE: begin
        if (o_accept) begin
          next_src      = dec_src;
          next_pc       = i_pc;
          next_disp     = dec_disp;
          next_psw      = i_psw;
          next_mem_addr = dec_addr;
          if (dec_src == cmpbr_pkg::SRC_IMM) begin
            next_opnd = dec_imm;
          end else begin
            next_opnd = i_acc;
          end
          // Long forms spend one cycle more before the read
          if (dec_long) begin
            next_len   = cmpbr_pkg::LEN_LONG;
            next_state = cmpbr_pkg::ST_CALC;
          end else begin
            next_len   = cmpbr_pkg::LEN_SHORT;
            next_state = cmpbr_pkg::ST_READ;
          end
        end
      end
      cmpbr_pkg::ST_CALC: begin
        next_state = cmpbr_pkg::ST_READ;
      end
      cmpbr_pkg::ST_READ: begin
        next_state = cmpbr_pkg::ST_CMP;
      end
      cmpbr_pkg::ST_CMP: begin
        next_state  = cmpbr_pkg::ST_IDLE;
        next_done   = 1'b1;
        next_branch = differ;
        if (differ) begin
          next_res_pc = pc + len + disp_ext;
        end else begin
          next_res_pc = pc + len;
        end
        next_res_psw = psw;
        next_res_psw[cmpbr_pkg::CARRY_BIT] = carry;
      end
      default: begin
        next_state = cmpbr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state      <= cmpbr_pkg::ST_IDLE;
      src        <= cmpbr_pkg::SRC_ACC;
      pc         <= cmpbr_pkg::PC_RST;
      len        <= cmpbr_pkg::LEN_SHORT;
      opnd       <= cmpbr_pkg::BYTE_RST;
      disp       <= cmpbr_pkg::BYTE_RST;
      psw        <= cmpbr_pkg::PSW_RST;
      o_mem_addr <= cmpbr_pkg::ADDR_RST;
      o_done     <= 1'b0;
      o_branch   <= 1'b0;
      o_pc       <= cmpbr_pkg::PC_RST;
      o_psw      <= cmpbr_pkg::PSW_RST;
    end else begin
      state      <= next_state;
      src        <= next_src;
      pc         <= next_pc;
      len        <= next_len;
      opnd       <= next_opnd;
      disp       <= next_disp;
      psw        <= next_psw;
      o_mem_addr <= next_mem_addr;
      o_done     <= next_done;
      o_branch   <= next_branch;
      o_pc       <= next_res_pc;
      o_psw      <= next_res_psw;
    end
  end

  // ==========================================================
  // Checks
  logic take_disp;
  logic take_short;
  logic take_long;
  logic cmp_imm;
  logic cmp_acc;

  assign take_disp  = o_accept && (i_op0 == cmpbr_pkg::OP_DISP_IND);
  assign take_long  = o_accept && (i_op0 == cmpbr_pkg::OP_DIR_LONG);
  assign take_short = o_accept && !dec_long;
  assign cmp_imm    = (state == cmpbr_pkg::ST_CMP) &&
                      (src == cmpbr_pkg::SRC_IMM);
  assign cmp_acc    = (state == cmpbr_pkg::ST_CMP) &&
                      (src == cmpbr_pkg::SRC_ACC);

  property p_disp_taken;
    @(posedge i_clk) disable iff (i_rst)
    cmp_imm && (i_mem_rdata != opnd) |=>
      o_done && o_branch &&
      (o_pc == $past(pc) + cmpbr_pkg::LEN_LONG + $past(disp_ext));
  endproperty
  a_disp_taken: assert property (p_disp_taken)
    else $error("indirect mismatch did not branch by 4 plus displacement");

  property p_disp_fall;
    @(posedge i_clk) disable iff (i_rst)
    cmp_imm && (i_mem_rdata == opnd) |=>
      o_done && !o_branch && (o_pc == $past(pc) + cmpbr_pkg::LEN_LONG);
  endproperty
  a_disp_fall: assert property (p_disp_fall)
    else $error("indirect match did not advance by 4");

  property p_disp_carry;
    @(posedge i_clk) disable iff (i_rst)
    cmp_imm |=> o_psw[cmpbr_pkg::CARRY_BIT] == $past(i_mem_rdata < opnd);
  endproperty
  a_disp_carry: assert property (p_disp_carry)
    else $error("indirect carry wrong");

  property p_disp_addr;
    @(posedge i_clk) disable iff (i_rst)
    take_disp |=> ##1 o_mem_rd &&
      (o_mem_addr == $past(i_ptr0, 2)
        + {{9{$past(i_op1[6], 2)}}, $past(i_op1[6:0], 2)});
  endproperty
  a_disp_addr: assert property (p_disp_addr)
    else $error("indirect operand address wrong");

  property p_long_cycles;
    @(posedge i_clk) disable iff (i_rst)
    o_accept && dec_long |=> o_busy [*3] ##1 (o_done && !o_busy);
  endproperty
  a_long_cycles: assert property (p_long_cycles)
    else $error("four-byte form not done after 3 cycles");

  property p_short_form;
    @(posedge i_clk) disable iff (i_rst)
    take_short |=> o_mem_rd && (o_mem_addr[7:0] == $past(i_op1))
      ##1 !o_mem_rd ##1 (o_done && !o_busy);
  endproperty
  a_short_form: assert property (p_short_form)
    else $error("short form address or 2-cycle timing wrong");

  property p_long_addr;
    @(posedge i_clk) disable iff (i_rst)
    take_long |=> !o_mem_rd ##1
      (o_mem_rd && o_mem_addr == {$past(i_op2, 2), $past(i_op1, 2)});
  endproperty
  a_long_addr: assert property (p_long_addr)
    else $error("long-range operand address wrong");

  property p_dir_taken;
    @(posedge i_clk) disable iff (i_rst)
    cmp_acc && (i_mem_rdata != opnd) |=>
      o_branch && (o_pc == $past(pc) + $past(len) + $past(disp_ext));
  endproperty
  a_dir_taken: assert property (p_dir_taken)
    else $error("direct mismatch target wrong");

  property p_dir_fall;
    @(posedge i_clk) disable iff (i_rst)
    cmp_acc && (i_mem_rdata == opnd) |=>
      !o_branch && (o_pc == $past(pc) + $past(len));
  endproperty
  a_dir_fall: assert property (p_dir_fall)
    else $error("direct match did not advance by length");

  property p_acc_carry;
    @(posedge i_clk) disable iff (i_rst)
    cmp_acc |=> o_psw[cmpbr_pkg::CARRY_BIT] == $past(opnd < i_mem_rdata);
  endproperty
  a_acc_carry: assert property (p_acc_carry)
    else $error("accumulator carry wrong");

  property p_other_flags;
    @(posedge i_clk) disable iff (i_rst)
    o_accept |=> ##2 (o_done or ##1 o_done) ##0
      ((o_psw ^ $past(psw)) & ~(8'h01 << cmpbr_pkg::CARRY_BIT)) == 8'h00;
  endproperty
  a_other_flags: assert property (p_other_flags)
    else $error("flag other than carry changed");

endmodule : cmpbr_exec

`default_nettype wire

/* verification/compare_branch_not_equal_bench.sv */
// Self-checking bench for the compare-and-branch-unequal executor.
// Assumes the bench plays both fetch and data memory, answering each
// read strobe with the byte in the following cycle.
`timescale 1ns/1ns
`default_nettype none

module compare_branch_not_equal_bench;

  // ==========================================================
  // Stimulus and observed signals
  logic                            i_clk;
  logic                            i_rst;
  logic                            i_start;
  logic [7:0]                      i_op0;
  logic [7:0]                      i_op1;
  logic [7:0]                      i_op2;
  logic [7:0]                      i_op3;
  logic [cmpbr_pkg::PC_W-1:0]      i_pc;
  logic [7:0]                      i_acc;
  logic [cmpbr_pkg::ADDR_W-1:0]    i_ptr0;
  logic [cmpbr_pkg::PSW_W-1:0]     i_psw;
  logic [7:0]                      i_mem_rdata;
  logic                            o_accept;
  logic                            o_reject;
  logic                            o_busy;
  logic                            o_mem_rd;
  logic [cmpbr_pkg::ADDR_W-1:0]    o_mem_addr;
  logic                            o_done;
  logic                            o_branch;
  logic [cmpbr_pkg::PC_W-1:0]      o_pc;
  logic [cmpbr_pkg::PSW_W-1:0]     o_psw;
  int                              mismatches;
  int                              checked;

  cmpbr_exec cmpbr_exec_inst (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_start     (i_start),
    .i_op0       (i_op0),
    .i_op1       (i_op1),
    .i_op2       (i_op2),
    .i_op3       (i_op3),
    .i_pc        (i_pc),
    .i_acc       (i_acc),
    .i_ptr0      (i_ptr0),
    .i_psw       (i_psw),
    .o_accept    (o_accept),
    .o_reject    (o_reject),
    .o_busy      (o_busy),
    .o_mem_rd    (o_mem_rd),
    .o_mem_addr  (o_mem_addr),
    .i_mem_rdata (i_mem_rdata),
    .o_done      (o_done),
    .o_branch    (o_branch),
    .o_pc        (o_pc),
    .o_psw       (o_psw)
  );

  always #4 i_clk = ~i_clk;

  // ==========================================================
  // Shared helpers
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  function automatic logic [16:0] npc(input logic [16:0] pc,
    input logic [16:0] len, input logic [7:0] d, input logic br);
    return br ? pc + len + {{9{d[7]}}, d} : pc + len;
  endfunction : npc

  // One full transfer; memory shows the inverse byte outside its slot
  task automatic exec_one(input logic [7:0] op0, op1, op2, op3,
    input logic [16:0] pc, input logic [7:0] acc, input logic [15:0] ptr0,
    input logic [7:0] psw, mem, input logic [15:0] ex_addr,
    input int ex_cyc, input logic ex_br, input logic [16:0] ex_pc,
    input logic [7:0] ex_psw);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_op0 <= op0;
    i_op1 <= op1;
    i_op2 <= op2;
    i_op3 <= op3;
    i_pc <= pc;
    i_acc <= acc;
    i_ptr0 <= ptr0;
    i_psw <= psw;
    i_mem_rdata <= ~mem;
    #1 check("accept", 32'h1, o_accept);
    check("reject", 32'h0, o_reject);
    @(posedge i_clk);
    i_start <= 1'b0;
    for (int k = 1; k <= ex_cyc + 1; k++) begin
      @(posedge i_clk);
      check("busy", k <= ex_cyc, o_busy);
      check("mem_rd", k == ex_cyc - 1, o_mem_rd);
      check("done", k == ex_cyc + 1, o_done);
      if (k == ex_cyc - 1) begin
        check("mem_addr", ex_addr, o_mem_addr);
        i_mem_rdata <= mem;
      end
      if (k == ex_cyc) begin
        i_mem_rdata <= ~mem;
      end
    end
    check("branch", ex_br, o_branch);
    check("pc", ex_pc, o_pc);
    check("psw", ex_psw, o_psw);
  endtask : exec_one

  // Displacement-indirect form, expectations worked out here
  task automatic t_ind(input logic [7:0] op1, imm, d, mem, psw,
                       input logic [15:0] ptr0, input logic [16:0] pc);
    logic [15:0] addr;
    logic [7:0]  ep;
    addr = ptr0 + {{9{op1[6]}}, op1[6:0]};
    ep = psw;
    ep[cmpbr_pkg::CARRY_BIT] = mem < imm;
    exec_one(cmpbr_pkg::OP_DISP_IND, op1, imm, d, pc, 8'h3C, ptr0, psw,
      mem, addr, cmpbr_pkg::CYC_LONG, mem != imm,
      npc(pc, cmpbr_pkg::LEN_LONG, d, mem != imm), ep);
  endtask : t_ind

  // Accumulator forms, short and long
  task automatic t_acc(input logic [7:0] op0, lo, b2, b3, acc, mem, psw,
                       input logic [16:0] pc);
    logic       lng;
    logic [7:0] pg;
    logic [7:0] d;
    logic [7:0] ep;
    lng = (op0 == cmpbr_pkg::OP_DIR_LONG);
    pg = lng ? b2 : (op0 == cmpbr_pkg::OP_DIR_PG00) ? cmpbr_pkg::PAGE_00 :
      (op0 == cmpbr_pkg::OP_DIR_PG01) ? cmpbr_pkg::PAGE_01 :
      cmpbr_pkg::PAGE_FE;
    d = lng ? b3 : b2;
    ep = psw;
    ep[cmpbr_pkg::CARRY_BIT] = acc < mem;
    exec_one(op0, lo, b2, b3, pc, acc, 16'h5A5A, psw, mem, {pg, lo},
      lng ? cmpbr_pkg::CYC_LONG : cmpbr_pkg::CYC_SHORT, acc != mem,
      npc(pc, lng ? cmpbr_pkg::LEN_LONG : cmpbr_pkg::LEN_SHORT, d,
      acc != mem), ep);
  endtask : t_acc

  // ==========================================================
  // Scenarios
  task automatic s_indirect;
    t_ind(8'h84, 8'h02, 8'h05, 8'h02, 8'hC5, 16'h0055, 17'h01F03);
    t_ind(8'h84, 8'h03, 8'h01, 8'h02, 8'h45, 16'h0055, 17'h01F07);
    t_ind(8'hC0, 8'h10, 8'hF0, 8'h90, 8'h7F, 16'h0010, 17'h00100);
    t_ind(8'hBF, 8'hFF, 8'h7F, 8'h00, 8'h00, 16'h0100, 17'h1FFF0);
  endtask : s_indirect

  task automatic s_direct_short;
    logic [7:0] ops [3];
    ops = '{cmpbr_pkg::OP_DIR_PG00, cmpbr_pkg::OP_DIR_PG01,
            cmpbr_pkg::OP_DIR_PGFE};
    for (int n = 0; n < 3; n++) begin
      t_acc(ops[n], 8'h55, 8'h07, 8'hEE, 8'h02, 8'h02, 8'hFF, 17'h01F06);
      t_acc(ops[n], 8'hA0, 8'h01, 8'hEE, 8'h01, 8'h02, 8'h3A, 17'h01F0C);
      t_acc(ops[n], 8'hFF, 8'h80, 8'h11, 8'hFF, 8'h01, 8'h80, 17'h00200);
    end
  endtask : s_direct_short

  task automatic s_long_range;
    t_acc(8'h16, 8'h00, 8'h02, 8'h08, 8'h02, 8'h02, 8'h81, 17'h01F06);
    t_acc(8'h16, 8'h00, 8'h02, 8'h01, 8'h01, 8'h02, 8'h01, 17'h01F0D);
    t_acc(8'h16, 8'hFF, 8'hFF, 8'h80, 8'h80, 8'h7F, 8'hFE, 17'h00010);
    t_acc(8'h16, 8'h30, 8'h00, 8'h7F, 8'h10, 8'hF0, 8'h00, 17'h1FFFC);
    t_acc(8'h16, 8'h00, 8'hFE, 8'h04, 8'h00, 8'h00, 8'h55, 17'h00400);
  endtask : s_long_range

  task automatic s_reject;
    logic [7:0] bad [3];
    bad = '{8'h11, cmpbr_pkg::OP_DISP_IND, 8'h17};
    for (int n = 0; n < 3; n++) begin
      @(posedge i_clk);
      i_start <= 1'b1;
      i_op0 <= bad[n];
      i_op1 <= 8'h04;
      #1 check("reject", 32'h1, o_reject);
      check("accept", 32'h0, o_accept);
      @(posedge i_clk);
      i_start <= 1'b0;
      #1 check("busy", 32'h0, o_busy);
    end
  endtask : s_reject

  // Request held while busy, then reset in mid-instruction
  task automatic s_reset_mid;
    @(posedge i_clk);
    i_start <= 1'b1;
    i_op0 <= cmpbr_pkg::OP_DIR_LONG;
    @(posedge i_clk);
    i_op0 <= cmpbr_pkg::OP_DIR_PG00;
    #1 check("accept_busy", 32'h0, o_accept);
    check("reject_busy", 32'h0, o_reject);
    @(posedge i_clk);
    i_start <= 1'b0;
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1 check("busy_rst", 32'h0, o_busy);
    check("mem_rd_rst", 32'h0, o_mem_rd);
    check("done_rst", 32'h0, o_done);
    check("pc_rst", cmpbr_pkg::PC_RST, o_pc);
    check("psw_rst", cmpbr_pkg::PSW_RST, o_psw);
    check("branch_rst", 32'h0, o_branch);
    check("addr_rst", cmpbr_pkg::ADDR_RST, o_mem_addr);
    // First transfer after the mid-run reset
    t_acc(cmpbr_pkg::OP_DIR_PG01, 8'h55, 8'h07, 8'hEE, 8'h02, 8'h03, 8'h00,
      17'h01F06);
  endtask : s_reset_mid

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_start = 1'b0;
    i_op0 = 8'h00;
    i_op1 = 8'h00;
    i_op2 = 8'h00;
    i_op3 = 8'h00;
    i_pc = '0;
    i_acc = 8'h00;
    i_ptr0 = 16'h0000;
    i_psw = 8'h00;
    i_mem_rdata = 8'h00;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    s_indirect();
    s_direct_short();
    s_long_range();
    s_reject();
    s_reset_mid();
    conclude();
  end

  // Whole run needs about 120 cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    mismatches++;
    conclude();
  end

endmodule : compare_branch_not_equal_bench

`default_nettype wire
